// [common/flash_front_regs.vh]
// Constants for the serial flash pin front end
`ifndef FLASH_FRONT_REGS_VH
`define FLASH_FRONT_REGS_VH

// =====================================================================
// Lane width codes
`define LW_SINGLE 2'h0
`define LW_DUAL 2'h1
`define LW_QUAD 2'h2

// =====================================================================
// Bit steps per serial clock edge
`define STEP_SINGLE 4'h1
`define STEP_DUAL 4'h2
`define STEP_QUAD 4'h4
`define BITS_PER_BYTE 4'h8

// =====================================================================
// Reset values and fill patterns
`define CNT_RST 4'h0
`define BYTE_RST 8'h00
`define IDLE_FILL 8'hFF
`define LANES_RST 4'h0
`define LANES_OFF 4'hF
`define PIN_SYNC_RST 1'h1
`define SYNC_WIDTH 6
`define SYNC_DEPTH 2'h2
`define FLUSH_RST 2'h0

// =====================================================================
// Pin function select encodings
`define PFS_PAUSE 1'h0
`define PFS_HWRESET 1'h1

`endif

// [rtl/pin_sync.v]
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/100ps
`include "flash_front_regs.vh"

module pin_sync #(
  parameter WIDTH = `SYNC_WIDTH
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Asynchronous pins and synchronised copies
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg stable_q;
      // Pins idle high, so both stages reset high
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q <= `PIN_SYNC_RST;
          stable_q <= `PIN_SYNC_RST;
        end else begin
          meta_q <= pin_in[i];
          stable_q <= meta_q;
        end
      end
      assign pin_out[i] = stable_q;
    end
  endgenerate

endmodule // pin_sync

// [rtl/flash_pin_front_end.v]
// Pin front end of a serial flash host interface (select, shift, lanes)
// Notes on behaviour
// R1 - While chip select is high every output lane is floated.
// R2 - A low chip select selects the device and wakes it from standby.
// R3 - A high chip select keeps the device in standby.
// R4 - Data lane bits are ignored while chip select is high.
// R5 - After reset nothing is accepted until a falling chip select is seen.
// R6 - Single lane input bits are taken from lane zero on rising clock.
// R7 - Single lane output bits go on lane one on falling clock.
// R8 - Dual and quad lanes sample on rising and drive on falling clock.
// R9 - Quad transfers use the protect pin as lane two, pause pin as three.
// R10 - The lane three pin is pause or hardware reset, pause by default.
// R11 - Select bit 0 makes lane three pause, bit 1 makes it reset.
// R12 - With quad enable set, protect and pause/reset functions are off.
// R13 - Pause low while selected floats output and freezes the transfer.
// R14 - Clock idle low or high (modes 0 and 3) both work.
// R15 - A rising chip select aborts the transfer and clears the counters.
`timescale 1ns/100ps
`include "flash_front_regs.vh"

module flash_pin_front_end (
  // System clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Serial pins from the host
  input wire CS_N,
  input wire SCK,
  // Data lanes: input, output, active low output enable
  input wire [3:0] LANE_IN,
  output wire [3:0] LANE_OUT,
  output wire [3:0] LANE_OE_N,
  // Configuration from the command core
  input wire [1:0] LANE_WIDTH,
  input wire OUT_PHASE,
  input wire QUAD_LANE_ENABLE,
  input wire PIN_FUNCTION_SELECT_BIT,
  // Transmit byte from the command core
  input wire [7:0] TX_BYTE,
  input wire TX_VALID,
  output wire TX_TAKEN,
  // Received bytes to the command core
  output wire [7:0] RX_BYTE,
  output wire RX_VALID,
  output wire RX_FIRST,
  // Status to the command core
  output wire SELECTED,
  output wire STANDBY,
  output wire PAUSED,
  output wire HW_RESET,
  output wire FRAME_END,
  output wire WRITE_PROTECT_N
);

  // ===================================================================
  // Decoding helpers
  function [3:0] step_of;
    input [1:0] w;
    begin
      case (w)
        `LW_DUAL: step_of = `STEP_DUAL;
        `LW_QUAD: step_of = `STEP_QUAD;
        default: step_of = `STEP_SINGLE;
      endcase
    end
  endfunction

  function [7:0] shift_in;
    input [7:0] s;
    input [1:0] w;
    input [3:0] l;
    begin
      case (w)
        `LW_DUAL: shift_in = {s[5:0], l[1:0]}; // [R8]
        `LW_QUAD: shift_in = {s[3:0], l}; // [R9]
        default: shift_in = {s[6:0], l[0]}; // [R6]
      endcase
    end
  endfunction

  function [3:0] lanes_of;
    input [7:0] s;
    input [1:0] w;
    begin
      case (w)
        `LW_DUAL: lanes_of = {2'h0, s[7], s[6]}; // [R8]
        `LW_QUAD: lanes_of = s[7:4]; // [R9]
        default: lanes_of = {2'h0, s[7], 1'h0}; // [R7]
      endcase
    end
  endfunction

  function [3:0] drive_mask;
    input [1:0] w;
    begin
      case (w)
        `LW_DUAL: drive_mask = 4'h3;
        `LW_QUAD: drive_mask = 4'hF;
        default: drive_mask = 4'h2;
      endcase
    end
  endfunction

  // ===================================================================
  // Pin synchronisers
  wire [5:0] sync_out;
  wire cs_n_s;
  wire sck_s;
  wire [3:0] lane_s;

  pin_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .pin_in({CS_N, SCK, LANE_IN}),
    .pin_out(sync_out)
  );

  assign cs_n_s = sync_out[5];
  assign sck_s = sync_out[4];
  assign lane_s = sync_out[3:0];

  // ===================================================================
  // State
  reg cs_d_q;
  reg sck_d_q;
  reg [1:0] flush_q;
  reg armed_q;
  reg armed_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg [7:0] sr_in_q;
  reg [7:0] sr_in_d;
  reg [7:0] sr_out_q;
  reg [7:0] sr_out_d;
  reg first_q;
  reg first_d;
  reg [7:0] rx_byte_q;
  reg [7:0] rx_byte_d;
  reg rx_valid_q;
  reg rx_valid_d;
  reg rx_first_q;
  reg rx_first_d;
  reg tx_taken_q;
  reg tx_taken_d;
  reg [3:0] out_q;
  reg [3:0] out_d;
  reg [3:0] oe_n_q;
  reg [3:0] oe_n_d;
  reg selected_q;
  reg standby_q;
  reg paused_q;
  reg hw_reset_q;
  reg frame_end_q;
  reg wp_n_q;

  // ===================================================================
  // Pin edge history
  // Sync stages reset idle high: first outputs are not pin samples.
  // Select edge history waits out the flush, so a select held low through
  // reset never reads as a falling edge.
  wire flushed = (flush_q == `SYNC_DEPTH);

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flush_q <= `FLUSH_RST;
      cs_d_q <= 1'b0;
      sck_d_q <= `PIN_SYNC_RST;
    end else begin
      if (!flushed) begin
        flush_q <= flush_q + 2'h1;
      end
      cs_d_q <= flushed & cs_n_s; // [R5]
      sck_d_q <= sck_s;
    end
  end

  // ===================================================================
  // Pin decode
  wire cs_fall = cs_d_q & ~cs_n_s;
  wire cs_rise = ~cs_d_q & cs_n_s;
  wire sck_rise = ~sck_d_q & sck_s; // [R14]
  wire sck_fall = sck_d_q & ~sck_s; // [R14]
  wire shared_free = ~QUAD_LANE_ENABLE; // [R12]
  wire pause_fn = shared_free &
    (PIN_FUNCTION_SELECT_BIT == `PFS_PAUSE); // [R10] [R11]
  wire reset_fn = shared_free &
    (PIN_FUNCTION_SELECT_BIT == `PFS_HWRESET); // [R11]
  wire hw_rst = reset_fn & ~lane_s[3];
  wire active = armed_q & ~cs_n_s & ~hw_rst; // [R2] [R4]
  wire pause = active & pause_fn & ~lane_s[3]; // [R13]
  wire run = active & ~pause;
  wire [3:0] step = step_of(LANE_WIDTH);
  wire [3:0] cnt_next = cnt_q + step;
  wire [7:0] load = TX_VALID ? TX_BYTE : `IDLE_FILL;
  wire [7:0] cur = (cnt_q == `CNT_RST) ? load : sr_out_q;

  // ===================================================================
  // Next state
  always @* begin
    armed_d = armed_q;
    cnt_d = cnt_q;
    sr_in_d = sr_in_q;
    sr_out_d = sr_out_q;
    first_d = first_q;
    rx_byte_d = rx_byte_q;
    rx_valid_d = 1'b0;
    rx_first_d = rx_first_q;
    tx_taken_d = 1'b0;
    out_d = out_q;
    oe_n_d = `LANES_OFF;
    if (cs_fall) begin
      armed_d = 1'b1; // [R5]
    end
    if (cs_n_s | hw_rst) begin
      // Abort: a fresh instruction follows the next selection
      cnt_d = `CNT_RST; // [R15]
      sr_in_d = `BYTE_RST;
      sr_out_d = `BYTE_RST;
      first_d = 1'b1;
      out_d = `LANES_RST;
    end else if (run) begin
      if (sck_rise && !OUT_PHASE) begin
        sr_in_d = shift_in(sr_in_q, LANE_WIDTH, lane_s); // [R6] [R8]
        if (cnt_next >= `BITS_PER_BYTE) begin
          cnt_d = `CNT_RST;
          rx_byte_d = shift_in(sr_in_q, LANE_WIDTH, lane_s);
          rx_valid_d = 1'b1;
          rx_first_d = first_q;
          first_d = 1'b0;
        end else begin
          cnt_d = cnt_next;
        end
      end
      if (sck_fall && OUT_PHASE) begin
        out_d = lanes_of(cur, LANE_WIDTH); // [R7] [R8]
        sr_out_d = cur << step;
        tx_taken_d = (cnt_q == `CNT_RST) & TX_VALID;
        cnt_d = (cnt_next >= `BITS_PER_BYTE) ? `CNT_RST : cnt_next;
      end
    end
    // Drive only while selected, not paused, in an output phase
    if (run && OUT_PHASE) begin
      oe_n_d = ~drive_mask(LANE_WIDTH); // [R1] [R13]
    end
  end

  // ===================================================================
  // Registers
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      armed_q <= 1'b0;
      cnt_q <= `CNT_RST;
      sr_in_q <= `BYTE_RST;
      sr_out_q <= `BYTE_RST;
      first_q <= 1'b1;
      rx_byte_q <= `BYTE_RST;
      rx_valid_q <= 1'b0;
      rx_first_q <= 1'b0;
      tx_taken_q <= 1'b0;
      out_q <= `LANES_RST;
      oe_n_q <= `LANES_OFF;
      selected_q <= 1'b0;
      standby_q <= 1'b1;
      paused_q <= 1'b0;
      hw_reset_q <= 1'b0;
      frame_end_q <= 1'b0;
      wp_n_q <= 1'b1;
    end else begin
      armed_q <= armed_d;
      cnt_q <= cnt_d;
      sr_in_q <= sr_in_d;
      sr_out_q <= sr_out_d;
      first_q <= first_d;
      rx_byte_q <= rx_byte_d;
      rx_valid_q <= rx_valid_d;
      rx_first_q <= rx_first_d;
      tx_taken_q <= tx_taken_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      selected_q <= active; // [R2]
      standby_q <= cs_n_s; // [R3]
      paused_q <= pause; // [R13]
      hw_reset_q <= hw_rst; // [R10]
      frame_end_q <= cs_rise & armed_q; // [R15]
      wp_n_q <= QUAD_LANE_ENABLE | lane_s[2]; // [R12]
    end
  end

  // ===================================================================
  // Outputs
  assign LANE_OUT = out_q;
  assign LANE_OE_N = oe_n_q;
  assign TX_TAKEN = tx_taken_q;
  assign RX_BYTE = rx_byte_q;
  assign RX_VALID = rx_valid_q;
  assign RX_FIRST = rx_first_q;
  assign SELECTED = selected_q;
  assign STANDBY = standby_q;
  assign PAUSED = paused_q;
  assign HW_RESET = hw_reset_q;
  assign FRAME_END = frame_end_q;
  assign WRITE_PROTECT_N = wp_n_q;

endmodule // flash_pin_front_end

// [tb/flash_front_properties.sv]
// Port-level properties of the flash pin front end
`timescale 1ns/100ps
module flash_front_properties (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Pins and status
  input wire CS_N,
  input wire [3:0] LANE_OE_N,
  input wire QUAD_LANE_ENABLE,
  input wire PIN_FUNCTION_SELECT_BIT,
  input wire RX_VALID,
  input wire TX_TAKEN,
  input wire SELECTED,
  input wire STANDBY,
  input wire PAUSED,
  input wire HW_RESET,
  input wire FRAME_END,
  input wire WRITE_PROTECT_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // ==================================
  // Select pin; six cycles cover sync lag
  a_cs_float: assert property (CS_N [*6] |-> LANE_OE_N == 4'hF)
    else $error("lanes driven while deselected");
  a_cs_standby: assert property (CS_N [*6] |-> STANDBY && !SELECTED)
    else $error("not in standby while deselected");
  a_cs_no_data: assert property (CS_N [*6] |-> !RX_VALID && !TX_TAKEN)
    else $error("data moved while deselected");
  a_rx_awake: assert property (RX_VALID |-> !STANDBY)
    else $error("byte taken in standby");
  a_end_clean: assert property (FRAME_END |-> ##[0:1] STANDBY && !SELECTED)
    else $error("frame end without deselect");
  // ==================================
  // Shared pins
  a_pause_float: assert property (PAUSED [*6] |-> LANE_OE_N[1])
    else $error("output driven while paused");
  a_reset_desel: assert property (HW_RESET [*2] |-> !SELECTED)
    else $error("selected during hardware reset");
  a_pause_mode: assert property (!PIN_FUNCTION_SELECT_BIT [*3] |-> !HW_RESET)
    else $error("reset while pause function chosen");
  a_quad_pins: assert property (QUAD_LANE_ENABLE [*3] |->
    WRITE_PROTECT_N && !HW_RESET && !PAUSED)
    else $error("pin functions active in quad");
  c_rx: cover property (RX_VALID);
  c_tx: cover property (TX_TAKEN);
  c_hw: cover property (HW_RESET);
  c_pause: cover property (PAUSED);
endmodule // flash_front_properties
bind flash_pin_front_end flash_front_properties u_flash_front_properties (
  .CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .LANE_OE_N(LANE_OE_N),
  .QUAD_LANE_ENABLE(QUAD_LANE_ENABLE), .RX_VALID(RX_VALID),
  .PIN_FUNCTION_SELECT_BIT(PIN_FUNCTION_SELECT_BIT), .TX_TAKEN(TX_TAKEN),
  .SELECTED(SELECTED), .STANDBY(STANDBY), .PAUSED(PAUSED),
  .HW_RESET(HW_RESET), .FRAME_END(FRAME_END),
  .WRITE_PROTECT_N(WRITE_PROTECT_N));

// [tb/spi_host_model.sv]
// Host controller model driving select, serial clock and lanes
`timescale 1ns/100ps
module spi_host_model (
  // Pacing clock
  input wire clk,
  // Resolved lane wires
  input wire [3:0] lane_wire,
  // Host pins
  output reg cs_n,
  output reg sck,
  output reg [3:0] drv
);
  initial begin
    cs_n = 1'b0;
    sck = 1'b0;
    drv = 4'hF;
  end
  // ==================================
  // Half of a 160 ns serial period
  task half;
    repeat (8) @(negedge clk);
  endtask
  // Idle clock level picks mode 0 or 3
  task frame(input on, input m);
    begin
      sck = m;
      half;
      cs_n = !on;
      half;
    end
  endtask
  // Present on low clock, sample on rising clock
  task shift(input [1:0] w, input [7:0] d, input [3:0] nb,
             output [7:0] q);
    reg [7:0] t;
    integer i;
    integer s;
    begin
      s = (w == 2'h2) ? 4 : (w == 2'h1) ? 2 : 1;
      q = 8'h00;
      for (i = 0; i < nb; i = i + s) begin
        sck = 1'b0;
        t = d << i;
        if (s == 4) drv = t[7:4];
        else if (s == 2) drv[1:0] = t[7:6];
        else drv[1:0] = {~drv[1], t[7]};
        half;
        sck = 1'b1;
        q = (q << s) | (s == 4 ? lane_wire : s == 2 ? lane_wire[1:0] :
          lane_wire[1]);
        half;
      end
    end
  endtask
endmodule // spi_host_model

// [tb/serial_flash_pin_front_end_tb.sv]
// Self-checking bench for the flash pin front end
`timescale 1ns/100ps
module serial_flash_pin_front_end_tb;
  reg CLK = 1'b0;
  reg SYS_RST = 1'b1;
  reg [1:0] lw = 2'h0;
  reg op = 1'b0;
  reg qe = 1'b0;
  reg pfs = 1'b0;
  reg [7:0] txb = 8'hA5;
  reg txv = 1'b1;
  wire cs_n, sck, tx_tk, rx_v, rx_f, sel, stby, pau, hwr, fe, wp_n;
  wire [3:0] drv, l_out, oe_n, lane_w;
  wire [7:0] rx_b;
  reg [7:0] q;
  integer n_fail = 0, comparisons = 0, n_rx = 0, n_tx = 0, n_fe = 0;
  always #5 CLK = ~CLK;
  assign lane_w = (oe_n & drv) | (~oe_n & l_out);
  always @(posedge CLK) begin
    n_rx <= n_rx + (rx_v === 1'b1);
    n_tx <= n_tx + (tx_tk === 1'b1);
    n_fe <= n_fe + (fe === 1'b1);
  end
  flash_pin_front_end u_flash_pin_front_end (.CLK(CLK), .SYS_RST(SYS_RST),
    .CS_N(cs_n), .SCK(sck), .LANE_IN(lane_w), .LANE_OUT(l_out),
    .LANE_OE_N(oe_n), .LANE_WIDTH(lw), .OUT_PHASE(op),
    .QUAD_LANE_ENABLE(qe), .PIN_FUNCTION_SELECT_BIT(pfs), .TX_BYTE(txb),
    .TX_VALID(txv), .TX_TAKEN(tx_tk), .RX_BYTE(rx_b), .RX_VALID(rx_v),
    .RX_FIRST(rx_f), .SELECTED(sel), .STANDBY(stby), .PAUSED(pau),
    .HW_RESET(hwr), .FRAME_END(fe), .WRITE_PROTECT_N(wp_n));
  spi_host_model u_host (.clk(CLK), .lane_wire(lane_w), .cs_n(cs_n),
    .sck(sck), .drv(drv));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ==================================
  // Scenarios
  task t_unarmed;
    begin
      chk({oe_n, stby, sel}, 8'h3C);
      u_host.shift(2'h0, 8'h9C, 4'h8, q);
      chk({n_rx[3:0], sel}, 8'h00);
      u_host.frame(1'b0, 1'b0);
      chk(n_fe[7:0], 8'h00);
    end
  endtask
  task t_single;
    begin
      u_host.frame(1'b1, 1'b0);
      chk({sel, stby}, 8'h02);
      u_host.shift(2'h0, 8'hFF, 4'h4, q);
      u_host.frame(1'b0, 1'b0);
      u_host.frame(1'b1, 1'b0);
      u_host.shift(2'h0, 8'h5A, 4'h8, q);
      chk(rx_b, 8'h5A);
      chk(rx_f, 8'h01);
      u_host.shift(2'h0, 8'h35, 4'h8, q);
      chk(rx_b, 8'h35);
      chk(rx_f, 8'h00);
      u_host.frame(1'b0, 1'b0);
      u_host.shift(2'h0, 8'hC0, 4'h8, q);
      chk({n_rx[3:0], n_fe[3:0]}, 8'h22);
    end
  endtask
  task t_multi;
    begin
      qe = 1'b1;
      lw = 2'h1;
      u_host.frame(1'b1, 1'b0);
      u_host.shift(2'h1, 8'hC3, 4'h8, q);
      chk(rx_b, 8'hC3);
      lw = 2'h2;
      u_host.shift(2'h2, 8'h7E, 4'h8, q);
      chk(rx_b, 8'h7E);
      u_host.frame(1'b0, 1'b0);
      u_host.drv[3:2] = 2'h3;
      lw = 2'h0;
      qe = 1'b0;
    end
  endtask
  task t_pause;
    begin
      u_host.frame(1'b1, 1'b0);
      u_host.shift(2'h0, 8'h60, 4'h4, q);
      u_host.drv[3] = 1'b0;
      u_host.half;
      chk({pau, oe_n[1]}, 8'h03);
      u_host.shift(2'h0, 8'h11, 4'h8, q);
      chk(rx_b, 8'h7E);
      u_host.drv[3] = 1'b1;
      u_host.half;
      u_host.shift(2'h0, 8'h60, 4'h4, q);
      chk(rx_b, 8'h66);
      pfs = 1'b1;
      u_host.drv[3] = 1'b0;
      u_host.half;
      chk({hwr, sel}, 8'h02);
      u_host.drv[3:2] = 2'h2;
      u_host.half;
      pfs = 1'b0;
      u_host.half;
      chk({hwr, sel, wp_n}, 8'h02);
      qe = 1'b1;
      u_host.half;
      chk(wp_n, 8'h01);
      u_host.drv[2] = 1'b1;
      u_host.frame(1'b0, 1'b0);
    end
  endtask
  task t_out;
    begin
      op = 1'b1;
      u_host.frame(1'b1, 1'b1);
      lw = 2'h2;
      txb = 8'h3C;
      u_host.shift(2'h2, 8'h00, 4'h8, q);
      chk(q, 8'h3C);
      lw = 2'h0;
      txb = 8'hA5;
      u_host.shift(2'h0, 8'h00, 4'h8, q);
      chk(q, 8'hA5);
      txv = 1'b0;
      u_host.shift(2'h0, 8'h00, 4'h8, q);
      chk(q, 8'hFF);
      chk(n_tx[7:0], 8'h02);
      u_host.frame(1'b0, 1'b1);
    end
  endtask
  initial begin
    repeat (6) @(negedge CLK);
    SYS_RST = 1'b0;
    repeat (4) @(negedge CLK);
    t_unarmed;
    t_single;
    t_multi;
    t_pause;
    t_out;
    finish_test;
  end
  initial begin
    #300000;
    n_fail = n_fail + 1;
    finish_test;
  end
endmodule // serial_flash_pin_front_end_tb
